/* hdl/xtg_enc.sv */
// 8b/10b data encoder with its own running disparity
`timescale 1ns/100ps
module xtg_enc (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       ce,
  // octet in
  input  wire logic       load,
  input  wire logic       first,
  input  wire logic       rd_in,
  input  wire logic [7:0] octet,
  // code-group out
  output logic      [9:0] code_q
);

  localparam logic [5:0] T6 [32] = '{
    6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17,
    6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
  localparam logic [3:0] T4 [8] = '{
    4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};

  logic       rd_q;
  logic       rd0;
  logic       rd1;
  logic       rd2;
  logic       alt7;
  logic [5:0] s6;
  logic [3:0] f4;

  // ----------------------------------------------------------------------
  // encode
  // ----------------------------------------------------------------------
  // the first group after the preamble takes the line disparity
  always_comb begin
    rd0  = first ? rd_in : rd_q;
    s6   = T6[octet[4:0]];
    if (rd0 && ($countones(s6) != 3 || octet[4:0] == 5'h07)) begin
      s6 = ~s6;
    end
    rd1  = ($countones(s6) != 3) ? ~rd0 : rd0;
    f4   = T4[octet[7:5]];
    alt7 = (octet[7:5] == 3'h7) &&
           ((!rd1 && s6[1:0] == 2'h3) || (rd1 && s6[1:0] == 2'h0));
    if (alt7) begin
      f4 = rd1 ? 4'h8 : 4'h7;
    end else if (rd1 && ($countones(f4) != 2 || octet[7:5] == 3'h3)) begin
      f4 = ~f4;
    end
    rd2  = ($countones(f4) != 2) ? ~rd1 : rd1;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      code_q <= 10'h000;
      rd_q   <= 1'b0;
    end else if (ce && load) begin
      code_q <= {s6, f4};
      rd_q   <= rd2;
    end
  end

endmodule

/* hdl/xtg_gen.sv */
// four-lane test pattern generator with deskew preamble and lane checker
//
// Summary of operation
// - serial bits go round-robin to lanes 0,1,2,3 then wrap.
// - high mode puts alternating one-zero on every lane.
// - high mode serial source is four zeros then four ones, repeated.
// - low mode puts runs of five ones and five zeros on each lane.
// - random stream is a 1512-octet payload, 8b/10b coded, in data phase.
// - jitter stream is a 1528-octet payload, 8b/10b coded, in data phase.
// - a deskew preamble precedes the data sequence.
// - sync group repeats with alternating disparity, negative first.
// - sixteen sync groups per lane, ending at serial bit 639, then align.
// - align starts at serial bit 640, negative; next sync positive.
// - sixteen syncs plus one align repeat N times, once when N is zero.
// - lane 0 then sends a start character after a sync and an align.
// - lanes 1 to 3 send a disparity-correct filler in that slot.
// - checker compares each lane with the lane-level reference.
// - errors are counted only in the payload phase.
// - align deskews, sync synchronises, start marks lane 0.
`timescale 1ns/100ps
`include "xtg_defs.svh"
module xtg_gen (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             ce,
  // control
  input  wire logic             start,
  input  wire logic             stop,
  input  wire logic [1:0]       mode,
  input  wire logic [7:0]       blk_n,
  // payload octets, lane i in bits 8i+7..8i
  input  wire logic [31:0]      pay_data,
  output logic      [8:0]       pay_idx_q,
  // lanes
  output logic      [3:0]       lane_q,
  output logic                  busy_q,
  output logic                  data_q,
  // checker
  input  wire logic [3:0]       rx_lane,
  output logic      [3:0][15:0] err_cnt_q
);

  xtg_pkg::xtg_state_e state_q;
  xtg_pkg::xtg_state_e state_d;
  xtg_pkg::xtg_mode_e  mode_q;
  logic [3:0]          bit_cnt_q;
  logic [3:0]          char_cnt_q;
  logic [7:0]          blk_cnt_q;
  logic [7:0]          sync_cyc_q;
  logic                rd_q;
  logic [3:0][9:0]     word_q;
  logic [3:0][9:0]     enc_code;
  logic [3:0]          nib;
  logic                bound;
  logic                load;
  logic                load_enc;
  logic                frame_md;
  logic                rd_sel;
  logic [3:0]          ref_q [`XTG_CHK_DLY];
  logic                ph_q  [`XTG_CHK_DLY];

  function automatic logic [9:0] sync_w(input logic rd);
    return rd ? `XTG_SYNC_POS : `XTG_SYNC_NEG;
  endfunction

  function automatic logic [9:0] align_w(input logic rd);
    return rd ? `XTG_ALIGN_POS : `XTG_ALIGN_NEG;
  endfunction

  function automatic logic is_pre(input xtg_pkg::xtg_state_e s);
    return s != xtg_pkg::XTG_ST_IDLE && s != xtg_pkg::XTG_ST_DATA;
  endfunction

  assign bound    = bit_cnt_q == `XTG_CHAR_LAST;
  assign frame_md = mode_q == xtg_pkg::XTG_MD_CRPAT ||
                    mode_q == xtg_pkg::XTG_MD_CJPAT;
  assign load     = ce && ((state_q == xtg_pkg::XTG_ST_IDLE && start) ||
                           (state_q != xtg_pkg::XTG_ST_IDLE && bound));
  assign load_enc = ce && bound && frame_md &&
                    state_d == xtg_pkg::XTG_ST_DATA;
  assign rd_sel   = (state_q == xtg_pkg::XTG_ST_IDLE) ? 1'b0 : rd_q;

  // ----------------------------------------------------------------------
  // sequence control
  // ----------------------------------------------------------------------
  // every move except the start from idle happens on a character boundary of all four lanes
  always_comb begin
    state_d = state_q;
    if (stop && bound && state_q != xtg_pkg::XTG_ST_IDLE) begin
      state_d = xtg_pkg::XTG_ST_IDLE;
    end else begin
      case (state_q)
        xtg_pkg::XTG_ST_IDLE: begin
          if (start) state_d = xtg_pkg::XTG_ST_SYNC;
        end
        xtg_pkg::XTG_ST_SYNC: begin
          if (bound && char_cnt_q == `XTG_SYNC_LAST) begin
            state_d = xtg_pkg::XTG_ST_ALIGN;
          end
        end
        xtg_pkg::XTG_ST_ALIGN: begin
          // a count of zero behaves as one block
          if (bound) begin
            state_d = (8'(blk_cnt_q + 8'h01) >= blk_n) ?
                      xtg_pkg::XTG_ST_LSYNC : xtg_pkg::XTG_ST_SYNC;
          end
        end
        xtg_pkg::XTG_ST_LSYNC: begin
          if (bound) state_d = xtg_pkg::XTG_ST_LALIGN;
        end
        xtg_pkg::XTG_ST_LALIGN: begin
          if (bound) state_d = xtg_pkg::XTG_ST_START;
        end
        xtg_pkg::XTG_ST_START: begin
          if (bound) state_d = xtg_pkg::XTG_ST_DATA;
        end
        xtg_pkg::XTG_ST_DATA: begin
          state_d = xtg_pkg::XTG_ST_DATA;
        end
        default: begin
          state_d = xtg_pkg::XTG_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= xtg_pkg::XTG_ST_IDLE;
      mode_q  <= xtg_pkg::XTG_MD_HIGH;
    end else if (ce) begin
      state_q <= state_d;
      if (state_q == xtg_pkg::XTG_ST_IDLE && start) begin
        mode_q <= xtg_pkg::xtg_mode_e'(mode);
      end
    end
  end

  // ----------------------------------------------------------------------
  // counters
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bit_cnt_q  <= 4'h0;
      char_cnt_q <= 4'h0;
      blk_cnt_q  <= 8'h00;
      sync_cyc_q <= 8'h00;
    end else if (ce) begin
      if (state_q == xtg_pkg::XTG_ST_IDLE) begin
        bit_cnt_q  <= 4'h0;
        char_cnt_q <= 4'h0;
        blk_cnt_q  <= 8'h00;
      end else begin
        bit_cnt_q <= bound ? 4'h0 : 4'(bit_cnt_q + 4'h1);
        if (bound && state_q == xtg_pkg::XTG_ST_SYNC) begin
          char_cnt_q <= 4'(char_cnt_q + 4'h1);
        end else if (bound && state_q == xtg_pkg::XTG_ST_ALIGN) begin
          char_cnt_q <= 4'h0;
          blk_cnt_q  <= 8'(blk_cnt_q + 8'h01);
        end
      end
      sync_cyc_q <= (state_q == xtg_pkg::XTG_ST_SYNC) ?
                    8'(sync_cyc_q + 8'h01) : 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // preamble code-groups
  // ----------------------------------------------------------------------
  // sync and align each flip disparity; start and filler are neutral
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      word_q <= '0;
      rd_q   <= 1'b0;
    end else if (load) begin
      case (state_d)
        xtg_pkg::XTG_ST_SYNC, xtg_pkg::XTG_ST_LSYNC: begin
          word_q <= {4{sync_w(rd_sel)}};
          rd_q   <= ~rd_sel;
        end
        xtg_pkg::XTG_ST_ALIGN, xtg_pkg::XTG_ST_LALIGN: begin
          word_q <= {4{align_w(rd_sel)}};
          rd_q   <= ~rd_sel;
        end
        xtg_pkg::XTG_ST_START: begin
          word_q[0] <= rd_sel ? `XTG_START_POS : `XTG_START_NEG;
          word_q[1] <= rd_sel ? `XTG_FILL_POS : `XTG_FILL_NEG;
          word_q[2] <= rd_sel ? `XTG_FILL_POS : `XTG_FILL_NEG;
          word_q[3] <= rd_sel ? `XTG_FILL_POS : `XTG_FILL_NEG;
        end
        default: begin
          word_q <= word_q;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // payload encoding
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pay_idx_q <= 9'h000;
    end else if (ce) begin
      if (state_q == xtg_pkg::XTG_ST_IDLE) begin
        pay_idx_q <= 9'h000;
      end else if (load_enc) begin
        if ((mode_q == xtg_pkg::XTG_MD_CRPAT &&
             pay_idx_q == `XTG_CRPAT_LAST) ||
            (mode_q == xtg_pkg::XTG_MD_CJPAT &&
             pay_idx_q == `XTG_CJPAT_LAST)) begin
          pay_idx_q <= 9'h000;
        end else begin
          pay_idx_q <= 9'(pay_idx_q + 9'h001);
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // per-lane serial nibble
  // ----------------------------------------------------------------------
  // lane i takes serial bit 4k+i, so the nibble is the serial source
  for (genvar i = 0; i < 4; i++) begin : g_lane
    xtg_enc xtg_enc_i (
      .clk    (clk),
      .nrst   (nrst),
      .ce     (ce),
      .load   (load_enc),
      .first  (state_q == xtg_pkg::XTG_ST_START),
      .rd_in  (rd_q),
      .octet  (pay_data[8*i +: 8]),
      .code_q (enc_code[i])
    );

    always_comb begin
      case (state_q)
        xtg_pkg::XTG_ST_IDLE: begin
          nib[i] = 1'b0;
        end
        xtg_pkg::XTG_ST_DATA: begin
          case (mode_q)
            xtg_pkg::XTG_MD_HIGH: nib[i] = bit_cnt_q[0];
            xtg_pkg::XTG_MD_LOW:  nib[i] = bit_cnt_q < `XTG_LOW_RUN;
            default: nib[i] = enc_code[i][`XTG_CHAR_LAST - bit_cnt_q];
          endcase
        end
        default: begin
          nib[i] = word_q[i][`XTG_CHAR_LAST - bit_cnt_q];
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lane_q <= 4'h0;
      busy_q <= 1'b0;
      data_q <= 1'b0;
    end else if (ce) begin
      lane_q <= nib;
      busy_q <= state_q != xtg_pkg::XTG_ST_IDLE;
      data_q <= state_q == xtg_pkg::XTG_ST_DATA;
    end
  end

  // ----------------------------------------------------------------------
  // lane checker
  // ----------------------------------------------------------------------
  // fixed loop latency; a receiver path of another depth needs a retune
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int k = 0; k < `XTG_CHK_DLY; k++) begin
        ref_q[k] <= 4'h0;
        ph_q[k]  <= 1'b0;
      end
    end else if (ce) begin
      ref_q[0] <= lane_q;
      ph_q[0]  <= data_q;
      for (int k = 1; k < `XTG_CHK_DLY; k++) begin
        ref_q[k] <= ref_q[k-1];
        ph_q[k]  <= ph_q[k-1];
      end
    end
  end

  for (genvar i = 0; i < 4; i++) begin : g_chk
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        err_cnt_q[i] <= 16'h0000;
      end else if (ce) begin
        if (state_q == xtg_pkg::XTG_ST_IDLE && start) begin
          err_cnt_q[i] <= 16'h0000;
        end else if (ph_q[`XTG_CHK_DLY-1] && err_cnt_q[i] != 16'hffff &&
                     rx_lane[i] != ref_q[`XTG_CHK_DLY-1][i]) begin
          err_cnt_q[i] <= 16'(err_cnt_q[i] + 16'h0001);
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  sequence s_high_run;
    data_q && mode_q == xtg_pkg::XTG_MD_HIGH && ce ##1 ce [*1];
  endsequence

  a_high_alt: assert property (@(posedge clk) disable iff (!nrst)
    s_high_run |-> (lane_q == ~$past(lane_q)) &&
                   (lane_q == 4'h0 || lane_q == 4'hf))
    else $error("high mode lanes do not alternate");

  a_low_run: assert property (@(posedge clk) disable iff (!nrst)
    (ce && state_q == xtg_pkg::XTG_ST_DATA &&
     mode_q == xtg_pkg::XTG_MD_LOW && bit_cnt_q == 4'h0) |->
    ##1 (lane_q == 4'hf && ce) [*5] ##1 lane_q == 4'h0)
    else $error("low mode run is not five ones");

  a_sync_count: assert property (@(posedge clk) disable iff (!nrst)
    (ce && state_q == xtg_pkg::XTG_ST_SYNC &&
     state_d == xtg_pkg::XTG_ST_ALIGN) |-> sync_cyc_q == `XTG_SYNC_CYC)
    else $error("sync run is not sixteen groups");

  a_sync_disp: assert property (@(posedge clk) disable iff (!nrst)
    (ce && bound && state_q == xtg_pkg::XTG_ST_SYNC &&
     state_d == xtg_pkg::XTG_ST_SYNC) |=> word_q[0] != $past(word_q[0]))
    else $error("sync disparity does not alternate");

  a_align_neg: assert property (@(posedge clk) disable iff (!nrst)
    (load && state_d == xtg_pkg::XTG_ST_ALIGN && blk_cnt_q == 8'h00) |=>
    word_q[0] == `XTG_ALIGN_NEG && rd_q)
    else $error("first align group not negative");

  a_blk_repeat: assert property (@(posedge clk) disable iff (!nrst)
    (ce && state_q == xtg_pkg::XTG_ST_ALIGN &&
     state_d == xtg_pkg::XTG_ST_LSYNC) |-> 8'(blk_cnt_q + 8'h01) >= blk_n)
    else $error("deskew blocks cut short");

  a_start_lanes: assert property (@(posedge clk) disable iff (!nrst)
    (load && state_d == xtg_pkg::XTG_ST_START && !rd_q) |=>
    word_q[0] == `XTG_START_NEG && word_q[3] == `XTG_FILL_NEG)
    else $error("start slot code-groups wrong");

  a_data_bound: assert property (@(posedge clk) disable iff (!nrst)
    (ce && state_q != xtg_pkg::XTG_ST_DATA &&
     state_d == xtg_pkg::XTG_ST_DATA) |->
    state_q == xtg_pkg::XTG_ST_START && bound)
    else $error("data phase entered off a boundary");

  a_err_gate: assert property (@(posedge clk) disable iff (!nrst)
    (ce && !ph_q[`XTG_CHK_DLY-1]) |=> $stable(err_cnt_q) || !busy_q)
    else $error("errors counted outside payload");

endmodule

/* inc/xtg_defs.svh */
// constants for the four-lane test pattern generator
`ifndef XTG_DEFS_SVH
`define XTG_DEFS_SVH

// ----------------------------------------------------------------------
// code-groups, transmitted left bit first (bit 9 first)
// ----------------------------------------------------------------------
`define XTG_SYNC_NEG   10'h0fa
`define XTG_SYNC_POS   10'h305
`define XTG_ALIGN_NEG  10'h0f3
`define XTG_ALIGN_POS  10'h30c
`define XTG_START_NEG  10'h368
`define XTG_START_POS  10'h097
`define XTG_FILL_NEG   10'h2b1
`define XTG_FILL_POS   10'h14e

// ----------------------------------------------------------------------
// sequence counts
// ----------------------------------------------------------------------
`define XTG_CHAR_LAST  4'h9
`define XTG_LOW_RUN    4'h5
`define XTG_SYNC_LAST  4'hf
`define XTG_SYNC_CYC   8'h9f
`define XTG_CRPAT_OCT  1512
`define XTG_CJPAT_OCT  1528
`define XTG_CRPAT_LAST 9'((`XTG_CRPAT_OCT / 4) - 1)
`define XTG_CJPAT_LAST 9'((`XTG_CJPAT_OCT / 4) - 1)
`define XTG_CHK_DLY    4

`endif

/* inc/xtg_pkg.sv */
// types for the four-lane test pattern generator
package xtg_pkg;

  typedef enum logic [2:0] {
    XTG_ST_IDLE   = 3'b000,
    XTG_ST_SYNC   = 3'b001,
    XTG_ST_ALIGN  = 3'b010,
    XTG_ST_LSYNC  = 3'b011,
    XTG_ST_LALIGN = 3'b100,
    XTG_ST_START  = 3'b101,
    XTG_ST_DATA   = 3'b110
  } xtg_state_e;

  typedef enum logic [1:0] {
    XTG_MD_HIGH  = 2'b00,
    XTG_MD_LOW   = 2'b01,
    XTG_MD_CRPAT = 2'b10,
    XTG_MD_CJPAT = 2'b11
  } xtg_mode_e;

endpackage

/* tb/xaui_lane_test_pattern_gen_test.sv */
// self-checking bench for the four-lane test pattern generator
`timescale 1ns/100ps
`include "xtg_defs.svh"
module xaui_lane_test_pattern_gen_test;
  // ----------------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------------
  logic             clk      = 1'b0;
  logic             nrst     = 1'b0;
  logic             ce       = 1'b1;
  logic             start    = 1'b0;
  logic             stop     = 1'b0;
  logic [1:0]       mode     = 2'h0;
  logic [7:0]       blk_n    = 8'h01;
  logic [31:0]      pay_data = 32'h0;
  logic [3:0]       flip     = 4'h0;
  logic [8:0]       pay_idx_q;
  logic [3:0]       lane_q;
  logic             busy_q;
  logic             data_q;
  logic [3:0]       rx_lane;
  logic [3:0][15:0] err_cnt_q;
  int               n_mismatch = 0;
  int               checks_done = 0;
  int               t = 0;
  int               cyc = 0;

  xtg_gen xtg_gen_i (.clk(clk), .nrst(nrst), .ce(ce), .start(start),
    .stop(stop), .mode(mode), .blk_n(blk_n), .pay_data(pay_data),
    .pay_idx_q(pay_idx_q), .lane_q(lane_q), .busy_q(busy_q),
    .data_q(data_q), .rx_lane(rx_lane), .err_cnt_q(err_cnt_q));

  xtg_rx_model xtg_rx_model_i (.clk(clk), .nrst(nrst), .ce(ce),
    .lane_in(lane_q), .flip(flip), .rx_lane(rx_lane));

  always #5 clk = ~clk;

  // payload looked up by index; any octet is a data octet
  always @(negedge clk) pay_data <= {4{pay_idx_q[7:0]}};

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ceiling well above the longest run, a hang ends in the report
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      wrap_up;
    end
  end

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // t counts samples taken while busy, to find character boundaries
  task automatic tick;
    @(negedge clk);
    if (busy_q) t++;
  endtask

  task automatic go(input logic [1:0] md, input logic [7:0] n);
    mode = md;
    blk_n = n;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    t = 0;
    for (int i = 0; i < 6 && !busy_q; i++) tick;
    cmp({15'h0, busy_q}, 16'h1);
  endtask

  task automatic stop_run;
    stop = 1'b1;
    for (int i = 0; i < 12 && busy_q; i++) tick;
    stop = 1'b0;
    cmp({15'h0, busy_q}, 16'h0);
    cmp(16'(t % 10), 16'h0);
    cmp({12'h0, lane_q}, 16'h0);
    // let the checker pipeline drain before the next start clears counts
    repeat (`XTG_CHK_DLY) tick;
  endtask

  task automatic chk_err(input logic [15:0] e2);
    for (int l = 0; l < 4; l++) begin
      cmp(err_cnt_q[l], l == 2 ? e2 : 16'h0);
    end
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic run_pre(input logic [1:0] md, input logic [7:0] n);
    int nb;
    int k;
    logic rd;
    logic [3:0][9:0] got;
    logic [9:0] e;
    logic [3:0] e4;
    nb = (n == 8'h00) ? 1 : int'(n);
    rd = 1'b0;
    go(md, n);
    for (int c = 0; c < nb * 17 + 3; c++) begin
      k = (c < nb * 17) ? ((c % 17 == 16) ? 1 : 0) : c - nb * 17;
      for (int b = 0; b < 10; b++) begin
        cmp({15'h0, data_q}, 16'h0);
        for (int l = 0; l < 4; l++) got[l] = {got[l][8:0], lane_q[l]};
        tick;
      end
      for (int l = 0; l < 4; l++) begin
        if (k == 0) e = rd ? `XTG_SYNC_POS : `XTG_SYNC_NEG;
        else if (k == 1) e = rd ? `XTG_ALIGN_POS : `XTG_ALIGN_NEG;
        else if (l == 0) e = rd ? `XTG_START_POS : `XTG_START_NEG;
        else e = rd ? `XTG_FILL_POS : `XTG_FILL_NEG;
        cmp({6'h0, got[l]}, {6'h0, e});
      end
      if (k < 2) rd = ~rd;
    end
    for (int b = 0; b < 20; b++) begin
      if (md == xtg_pkg::XTG_MD_HIGH) e4 = (b % 2 == 1) ? 4'hf : 4'h0;
      else e4 = (b % 10 < 5) ? 4'hf : 4'h0;
      cmp({11'h0, data_q, lane_q}, {11'h0, 1'b1, e4});
      tick;
    end
    stop_run;
    $display("preamble test done, mode %0d", md);
  endtask

  task automatic run_err;
    logic [3:0] held;
    go(xtg_pkg::XTG_MD_HIGH, 8'h01);
    flip = 4'h1;
    repeat (5) tick;
    flip = 4'h0;
    // a low enable must freeze the lanes in mid-character
    ce = 1'b0;
    held = lane_q;
    repeat (2) tick;
    cmp({12'h0, lane_q}, {12'h0, held});
    ce = 1'b1;
    t = t - 2;
    for (int i = 0; i < 400 && !data_q; i++) tick;
    repeat (10) tick;
    flip = 4'h4;
    repeat (7) tick;
    flip = 4'h0;
    repeat (8) tick;
    chk_err(16'h7);
    stop_run;
    $display("error count test done");
  endtask

  task automatic run_pay(input logic [1:0] md, input logic [8:0] last);
    logic [8:0] mx;
    logic wr;
    logic [3:0][9:0] got;
    mx = 9'h0;
    wr = 1'b0;
    go(md, 8'h01);
    chk_err(16'h0);
    for (int i = 0; i < 400 && !data_q; i++) tick;
    // first group is octet 00 on every lane, entered at positive disparity
    for (int b = 0; b < 10; b++) begin
      for (int l = 0; l < 4; l++) got[l] = {got[l][8:0], lane_q[l]};
      tick;
    end
    for (int l = 0; l < 4; l++) begin
      cmp({6'h0, got[l]}, 16'h018b);
    end
    for (int i = 0; i < (int'(last) + 3) * 10; i++) begin
      if (pay_idx_q === 9'h0 && mx === last) wr = 1'b1;
      if (pay_idx_q > mx) mx = pay_idx_q;
      tick;
    end
    cmp({7'h0, mx}, {7'h0, last});
    cmp({15'h0, wr}, 16'h1);
    chk_err(16'h0);
    stop_run;
    $display("payload test done, mode %0d", md);
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    run_pre(xtg_pkg::XTG_MD_HIGH, 8'h02);
    run_pre(xtg_pkg::XTG_MD_LOW, 8'h00);
    run_err;
    run_pay(xtg_pkg::XTG_MD_CRPAT, 9'h179);
    run_pay(xtg_pkg::XTG_MD_CJPAT, 9'h17d);
    wrap_up;
  end
endmodule

/* tb/xtg_rx_model.sv */
// receive-lane model of the unit under test: fixed lane latency, bit flips
`timescale 1ns/100ps
module xtg_rx_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       ce,
  // lanes
  input  wire logic [3:0] lane_in,
  input  wire logic [3:0] flip,
  output logic      [3:0] rx_lane
);
  // ----------------------------------------------------------------------
  // lane delay
  // ----------------------------------------------------------------------
  logic [3:0][3:0] dly_q;

  // lanes already deskewed, so one shared four-cycle delay
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dly_q <= '0;
    end else if (ce) begin
      dly_q <= {dly_q[2:0], lane_in};
    end
  end

  // flips only on bench command, so error counts can be provoked
  assign rx_lane = dly_q[3] ^ flip;
endmodule
